// [include/css_pkg.sv]
// Constants and types shared by the channel service scheduler
package css_pkg;
	// =====================================================
	// Geometry and order codes
	localparam int          NCH         = 16;
	localparam logic [5:0]  FC_SETUP_A  = 6'h29;
	localparam logic [5:0]  FC_SETUP_B  = 6'h2d;
	localparam logic [5:0]  FC_RAMCTL   = 6'h15;
	localparam logic [5:0]  FC_PCTL     = 6'h01;
	localparam logic [5:0]  FC_LOADMON  = 6'h14;
	localparam int          DIR_BIT     = 2;
	localparam int          SEL_LO_BIT  = 14;
	localparam int          SEL_HI_BIT  = 15;
	localparam int          RR_MODE_BIT = 0;
	// =====================================================
	// Pause and event constants
	localparam logic [5:0]  PAUSE_LIMIT = 6'h20;
	localparam logic [2:0]  LR_IN_FREE  = 3'h5;
	localparam logic [2:0]  LR_OUT_FREE = 3'h2;
	localparam logic [7:0]  EVT_MASK    = 8'hfc;
	// =====================================================
	// Block mode address map and reset values
	localparam logic [13:0] LINE_TOP    = 14'h01ff;
	localparam logic [13:0] CCB_LO      = 14'h0e00;
	localparam logic [13:0] CCB_HI      = 14'h0fff;
	localparam logic [15:0] LOAD_RST    = 16'h0000;
	localparam logic [1:0]  SP_RST      = 2'h0;
	// =====================================================
	// Enumerations and carriers
	typedef enum logic [1:0] {SVC_IDLE = 2'b00, SVC_DATA = 2'b01, SVC_EXEC = 2'b10, SVC_EVENT = 2'b11} svc_t;
	typedef enum logic [1:0] {XF_IDLE = 2'b00, XF_SETUP = 2'b01, XF_ADDR = 2'b10, XF_RUN = 2'b11} xfer_t;
	typedef enum logic [1:0] {RG_LINE = 2'b00, RG_CCB = 2'b01, RG_PROG = 2'b10} region_t;
	typedef struct packed {
		logic [5:0]  fc;
		logic [3:0]  chan;
		logic [15:0] data;
		logic [15:0] aux;
	} order_t;
	typedef struct packed {
		logic        valid;
		logic        io;
		logic        io_in;
		logic [2:0]  lr;
		logic        wait_y;
		logic        call;
		logic        ret;
		logic [13:0] next_pc;
		logic [13:0] vector;
	} instr_t;
endpackage

// [verilog/channel_service_scheduler.sv]
// Channel service scheduler, executive transfer and background chores
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Third control order selects RAM, starts
// - Transfer runs only with no data requests
// - Completion sets done flag, reports channel
// - Transfer error stops it, flags error
// - Line half selects visible tables
// - Block address selects table, block, program
// - Block write stops channel, optional interrupt
// - Scan compares status, acts on change
// - Load counter counts event passes
// - Vectored call pushes return, return pops
// - Requests served, next chosen by priority
// - Yield saves context, event yields release
// - Pause saves context, tallies, rearbitrates
// - Transfer pauses each byte, untallied
// - Forced pause after 32 instructions
// - Pause disable bit stops I/O pauses in any service, the count limit only in data
// - Line register I/O pauses, two exceptions
// - Data, then executive, then events
// - Data service fixed or round robin
// - Event pending when activity bits 2-7 set
// - Nonzero pointer gives separate context
module channel_service_scheduler (
	input  wire logic                 clock,
	input  wire logic                 arst_n,
	input  wire logic                 order_valid,
	input  wire css_pkg::order_t      order,
	input  wire css_pkg::instr_t      instr,
	input  wire logic [15:0]          data_req_hi,
	input  wire logic [15:0]          data_req_lo,
	input  wire logic [15:0][7:0]     activity,
	input  wire logic [15:0]          pause_dis,
	input  wire logic [15:0]          evt_ptr_nz,
	input  wire logic                 xfer_byte_done,
	input  wire logic                 xfer_error,
	input  wire logic [7:0]           scan_status,
	input  wire logic [7:0]           scan_mask,
	input  wire logic [15:0]          scan_en,
	input  wire logic                 blk_valid,
	input  wire logic [13:0]          blk_addr,
	input  wire logic [3:0]           blk_line,
	input  wire logic                 blk_wr_done,
	input  wire logic [15:0]          blk_level_set,
	output css_pkg::svc_t             grant_q,
	output logic [3:0]                grant_chan_q,
	output logic                      ctx_save_q,
	output logic                      ctx_separate_q,
	output logic                      tally_inc_q,
	output logic                      pc_load_q,
	output logic [13:0]               pc_q,
	output logic                      xfer_req_q,
	output logic                      xfer_dir_q,
	output logic                      xfer_ram_sel_q,
	output logic [15:0]               xfer_host_addr_q,
	output logic [13:0]               xfer_ram_addr_q,
	output logic                      rtt_set_q,
	output logic                      rtt_err_q,
	output logic [3:0]                rtt_chan_q,
	output logic                      answer_valid_q,
	output logic [15:0]               answer_q,
	output logic                      scan_rd_q,
	output logic [3:0]                scan_chan_q,
	output logic                      scan_act_q,
	output css_pkg::region_t          blk_region_q,
	output logic [13:0]               blk_phys_q,
	output logic                      blk_stop_q,
	output logic                      blk_intr_q,
	output logic [3:0]                blk_chan_q
);
	// =====================================================
	// Helpers
	// Round-robin search: first set bit after start, wrapping
	function automatic logic [4:0] rr_pick(input logic [15:0] v, input logic [3:0] start);
		logic [4:0] r;
		logic [3:0] k;
		r = 5'h00;
		for (int i = 15; i >= 0; i--)
		begin
			k = 4'(start + 4'(i) + 4'h1);
			if (v[k])
				r = {1'b1, k};
		end
		return r;
	endfunction

	css_pkg::xfer_t xf_q;
	logic [15:0] load_q, range_q, evt_req, data_req;
	logic [3:0]  data_ptr_q, evt_ptr_q, scan_ptr_q;
	logic [5:0]  ins_cnt_q;
	logic        rr_mode_q, scan_due_q, scan_wait_q, load_inc;
	logic [4:0]  data_pick, evt_pick;
	logic [7:0]  prev_q [16];
	logic [13:0] stack_q [16][4];
	logic [1:0]  sp_q [16];
	logic        pause_now, yield_now, io_forced, xf_go, rel_q;

	// Event pending from activity bits 2-7; data from either group
	always_comb
	begin
		for (int i = 0; i < 16; i++)
			evt_req[i] = |(activity[i] & css_pkg::EVT_MASK);
		data_req = data_req_hi | data_req_lo;
		if (rr_mode_q)
			data_pick = rr_pick(data_req, data_ptr_q);
		else if (|data_req_hi)
			data_pick = rr_pick(data_req_hi, 4'hf);
		else
			data_pick = rr_pick(data_req_lo, 4'hf);
		evt_pick = rr_pick(evt_req, evt_ptr_q);
	end

	// Line register I/O forces a pause except status in and config out
	assign io_forced = instr.io && !(instr.io_in && instr.lr == css_pkg::LR_IN_FREE)
		&& !(!instr.io_in && instr.lr == css_pkg::LR_OUT_FREE) && !pause_dis[grant_chan_q];
	assign pause_now = instr.valid && !instr.wait_y && (grant_q == css_pkg::SVC_DATA || grant_q == css_pkg::SVC_EVENT)
		&& (io_forced || (ins_cnt_q == css_pkg::PAUSE_LIMIT - 6'h01
		&& !(grant_q == css_pkg::SVC_DATA && pause_dis[grant_chan_q])));
	assign yield_now = instr.valid && instr.wait_y && (grant_q == css_pkg::SVC_DATA || grant_q == css_pkg::SVC_EVENT);
	assign xf_go = xf_q == css_pkg::XF_RUN;
	assign load_inc = grant_q == css_pkg::SVC_IDLE && !rel_q && data_req == 16'h0000 && !xf_go && !scan_due_q
		&& (!evt_pick[4] || evt_pick[3:0] <= evt_ptr_q);

	// =====================================================
	// Arbiter: a program grant held until it yields or pauses; executive for one byte or scan read
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			grant_q      <= css_pkg::SVC_IDLE;
			grant_chan_q <= 4'h0;
			data_ptr_q   <= 4'hf;
			evt_ptr_q    <= 4'hf;
			ctx_save_q   <= 1'b0;
			tally_inc_q  <= 1'b0;
			rel_q        <= 1'b0;
			ctx_separate_q <= 1'b0;
		end
		else
		begin
			ctx_save_q  <= 1'b0;
			tally_inc_q <= 1'b0;
			rel_q       <= 1'b0;
			case (grant_q)
				css_pkg::SVC_IDLE:
				begin
					// Data first, executive next, events last
					if (!rel_q && data_pick[4])
					begin
						grant_q      <= css_pkg::SVC_DATA;
						grant_chan_q <= data_pick[3:0];
						data_ptr_q   <= data_pick[3:0];
						ctx_separate_q <= evt_ptr_nz[data_pick[3:0]];
					end
					else if (!rel_q && (xf_go || scan_due_q))
						grant_q <= css_pkg::SVC_EXEC;
					else if (!rel_q && evt_pick[4])
					begin
						grant_q      <= css_pkg::SVC_EVENT;
						grant_chan_q <= evt_pick[3:0];
						evt_ptr_q    <= evt_pick[3:0];
						ctx_separate_q <= evt_ptr_nz[evt_pick[3:0]];
					end
				end
				css_pkg::SVC_EXEC:
				begin
					// Transfer gives way after every byte; pauses are not tallied
					if (!xf_go || xfer_byte_done || xfer_error || scan_wait_q)
						grant_q <= css_pkg::SVC_IDLE;
				end
				default:
				begin
					// Paused channel competes again on the next arbitration
					if (pause_now || yield_now)
					begin
						grant_q     <= css_pkg::SVC_IDLE;
						ctx_save_q  <= 1'b1;
						tally_inc_q <= pause_now;
						// An event-level wait always releases for one cycle
						rel_q       <= yield_now && grant_q == css_pkg::SVC_EVENT;
					end
				end
			endcase
		end
	end

	// Instruction count since the grant
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			ins_cnt_q <= 6'h00;
		else if (grant_q == css_pkg::SVC_IDLE || pause_now || yield_now)
			ins_cnt_q <= 6'h00;
		else if (instr.valid)
			ins_cnt_q <= ins_cnt_q + 6'h01;
	end

	// Load counter counts passes and wraps without a flag; read by order
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			load_q         <= css_pkg::LOAD_RST;
			answer_valid_q <= 1'b0;
			answer_q       <= 16'h0000;
		end
		else
		begin
			if (load_inc)
				load_q <= load_q + 16'h0001;
			answer_valid_q <= order_valid && order.fc == css_pkg::FC_LOADMON;
			if (order_valid && order.fc == css_pkg::FC_LOADMON)
				answer_q <= load_q;
		end
	end

	// =====================================================
	// Executive RAM transfer: three orders, then background bytes
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			xf_q             <= css_pkg::XF_IDLE;
			rr_mode_q        <= 1'b0;
			xfer_dir_q       <= 1'b0;
			xfer_ram_sel_q   <= 1'b0;
			xfer_host_addr_q <= 16'h0000;
			xfer_ram_addr_q  <= 14'h0000;
			range_q          <= 16'h0000;
			rtt_set_q        <= 1'b0;
			rtt_err_q        <= 1'b0;
			rtt_chan_q       <= 4'h0;
			xfer_req_q       <= 1'b0;
		end
		else
		begin
			rtt_set_q  <= 1'b0;
			xfer_req_q <= grant_q == css_pkg::SVC_EXEC && xf_go && !xfer_byte_done && !xfer_error;
			if (order_valid && order.fc == css_pkg::FC_PCTL)
				rr_mode_q <= order.data[css_pkg::RR_MODE_BIT];
			if (xf_go && (xfer_error || (xfer_req_q && xfer_byte_done && range_q <= 16'h0001)))
			begin
				// Error stops at once; both ends report on the setup channel
				xf_q      <= css_pkg::XF_IDLE;
				rtt_set_q <= 1'b1;
				rtt_err_q <= xfer_error;
			end
			else if (xf_go && xfer_req_q && xfer_byte_done)
			begin
				xfer_host_addr_q <= xfer_host_addr_q + 16'h0001;
				xfer_ram_addr_q  <= xfer_ram_addr_q + 14'h0001;
				range_q          <= range_q - 16'h0001;
			end
			else if (order_valid && !xf_go)
			begin
				if (order.fc == css_pkg::FC_SETUP_A || order.fc == css_pkg::FC_SETUP_B)
				begin
					xf_q             <= css_pkg::XF_SETUP;
					rtt_chan_q       <= order.chan;
					xfer_dir_q       <= order.fc[css_pkg::DIR_BIT];
					xfer_host_addr_q <= order.aux;
					range_q          <= order.data;
				end
				else if (order.fc == css_pkg::FC_RAMCTL && xf_q == css_pkg::XF_SETUP)
				begin
					xf_q            <= css_pkg::XF_ADDR;
					xfer_ram_addr_q <= order.data[13:0];
				end
				else if (order.fc == css_pkg::FC_PCTL && xf_q == css_pkg::XF_ADDR
					&& (order.data[css_pkg::SEL_LO_BIT] || order.data[css_pkg::SEL_HI_BIT]))
				begin
					xf_q           <= css_pkg::XF_RUN;
					xfer_ram_sel_q <= order.data[css_pkg::SEL_HI_BIT];
				end
			end
		end
	end

	// =====================================================
	// Status scan: one channel per executive grant, once per pass
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			scan_due_q  <= 1'b0;
			scan_wait_q <= 1'b0;
			scan_ptr_q  <= 4'h0;
			scan_rd_q   <= 1'b0;
			scan_chan_q <= 4'h0;
			scan_act_q  <= 1'b0;
		end
		else
		begin
			// The last channel of a pass must not launch a stray read of the next one
			scan_rd_q  <= grant_q == css_pkg::SVC_IDLE && !rel_q && !data_pick[4] && !xf_go && scan_due_q
				&& !(scan_wait_q && scan_ptr_q == 4'hf);
			scan_act_q <= 1'b0;
			if (scan_rd_q)
			begin
				scan_chan_q <= scan_ptr_q;
				scan_wait_q <= 1'b1;
			end
			else if (scan_wait_q)
			begin
				scan_wait_q <= 1'b0;
				scan_act_q  <= scan_en[scan_chan_q] && |((scan_status ^ prev_q[scan_chan_q]) & scan_mask);
				scan_ptr_q  <= scan_ptr_q + 4'h1;
				if (scan_ptr_q == 4'hf)
					scan_due_q <= 1'b0;
			end
			else if (load_inc)
				scan_due_q <= 1'b1;
		end
	end

	// Last status seen per channel; cleared so the first pass never compares unknowns
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < 16; i++)
				prev_q[i] <= 8'h00;
		end
		else if (scan_wait_q)
			prev_q[scan_chan_q] <= scan_status;
	end

	// =====================================================
	// Vectored call and return through a small per-channel stack
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pc_load_q <= 1'b0;
			pc_q      <= 14'h0000;
			for (int i = 0; i < 16; i++)
				sp_q[i] <= css_pkg::SP_RST;
		end
		else
		begin
			pc_load_q <= instr.valid && (instr.call || instr.ret) && grant_q != css_pkg::SVC_IDLE;
			if (instr.valid && instr.call && grant_q != css_pkg::SVC_IDLE)
			begin
				pc_q <= instr.vector;
				sp_q[grant_chan_q] <= sp_q[grant_chan_q] + 2'h1;
			end
			else if (instr.valid && instr.ret && grant_q != css_pkg::SVC_IDLE)
			begin
				pc_q <= stack_q[grant_chan_q][sp_q[grant_chan_q] - 2'h1];
				sp_q[grant_chan_q] <= sp_q[grant_chan_q] - 2'h1;
			end
		end
	end

	// Return points; a fifth nested call overwrites the oldest
	always_ff @(posedge clock)
	begin
		if (instr.valid && instr.call && grant_q != css_pkg::SVC_IDLE)
			stack_q[grant_chan_q][sp_q[grant_chan_q]] <= instr.next_pc;
	end

	// =====================================================
	// Block mode map and write completion
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			blk_region_q <= css_pkg::RG_PROG;
			blk_phys_q   <= 14'h0000;
			blk_stop_q   <= 1'b0;
			blk_intr_q   <= 1'b0;
			blk_chan_q   <= 4'h0;
		end
		else
		begin
			if (blk_valid)
			begin
				// Tables carry the line half in the top bit; program is shared
				if (blk_addr <= css_pkg::LINE_TOP)
					blk_region_q <= css_pkg::RG_LINE;
				else if (blk_addr >= css_pkg::CCB_LO && blk_addr <= css_pkg::CCB_HI)
					blk_region_q <= css_pkg::RG_CCB;
				else
					blk_region_q <= css_pkg::RG_PROG;
				if (blk_addr <= css_pkg::LINE_TOP || (blk_addr >= css_pkg::CCB_LO && blk_addr <= css_pkg::CCB_HI))
					blk_phys_q <= {blk_line[3], blk_addr[12:0]};
				else
					blk_phys_q <= blk_addr;
			end
			blk_stop_q <= blk_wr_done;
			blk_intr_q <= blk_wr_done && blk_level_set[blk_line];
			if (blk_wr_done)
				blk_chan_q <= blk_line;
		end
	end

	// =====================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	data_first_a: assert property ((grant_q == css_pkg::SVC_IDLE && !rel_q && data_req != 16'h0000) |=> grant_q == css_pkg::SVC_DATA) else $error("data request not served first");
	xfer_bg_a: assert property (xfer_req_q |-> $past(grant_q) == css_pkg::SVC_EXEC) else $error("transfer outside executive slot");
	rtt_err_a: assert property ((xf_go && xfer_error) |=> rtt_set_q && rtt_err_q && xf_q == css_pkg::XF_IDLE) else $error("error did not stop transfer");
	xfer_pause_a: assert property ((grant_q == css_pkg::SVC_EXEC && xfer_byte_done) |=> grant_q == css_pkg::SVC_IDLE && !tally_inc_q) else $error("byte pause wrong");
	pause_limit_a: assert property ((instr.valid && !instr.wait_y && ins_cnt_q == 6'h1f
		&& (grant_q == css_pkg::SVC_EVENT || (grant_q == css_pkg::SVC_DATA && !pause_dis[grant_chan_q])))
		|=> tally_inc_q && ctx_save_q) else $error("no pause at limit");
	free_io_a: assert property ((grant_q == css_pkg::SVC_DATA && instr.valid && instr.io && instr.io_in && instr.lr == 3'h5 && ins_cnt_q < 6'h1f) |=> !tally_inc_q) else $error("status input paused");
	load_wrap_a: assert property (load_inc |=> load_q == $past(load_q) + 16'h0001) else $error("load counter no wrap");
	start_run_a: assert property ((order_valid && order.fc == 6'h01 && xf_q == css_pkg::XF_ADDR && order.data[15:14] != 2'h0 && !xf_go) |=> xf_q == css_pkg::XF_RUN) else $error("third order did not start");
	blk_intr_a: assert property ((blk_wr_done && !blk_level_set[blk_line]) |=> blk_stop_q && !blk_intr_q) else $error("block interrupt without level");
	call_ret_a: assert property ((instr.valid && instr.call && grant_q != css_pkg::SVC_IDLE)
		##4 (instr.valid && instr.ret && grant_q != css_pkg::SVC_IDLE) |=> pc_q == $past(instr.next_pc, 5))
		else $error("return address lost");
	xfer_done_c: cover property (rtt_set_q && !rtt_err_q);
	pause_c: cover property (tally_inc_q);
	scan_act_c: cover property (scan_act_q);
endmodule
`default_nettype wire

// [tb/host_cpu_model.sv]
// Host processor model that issues transfer and load monitor orders
`timescale 1ns/1ns
`default_nettype none
module host_cpu_model (
	input  wire logic        clock,
	input  wire logic        start,
	input  wire logic        rd_load,
	input  wire logic        busy,
	input  wire logic [3:0]  chan,
	input  wire logic        dir,
	input  wire logic        ram_hi,
	input  wire logic        rr,
	input  wire logic [15:0] count,
	input  wire logic [15:0] host_addr,
	input  wire logic [13:0] ram_addr,
	output logic             order_valid,
	output css_pkg::order_t  order
);
	logic [1:0] step_q;
	initial
	begin
		order_valid = 1'b0;
		order = '0;
		step_q = 2'h0;
	end
	// ====
	// Order sequencer
	// One order a cycle, changed just after the falling edge
	always @(negedge clock)
	begin
		if (step_q == 2'h0 && rd_load)
		begin
			order_valid <= 1'b1;
			order <= '{css_pkg::FC_LOADMON, chan, 16'h0000, 16'h0000};
		end
		else if (step_q == 2'h0 && start && !busy)
		begin
			step_q <= 2'h1;
			order_valid <= 1'b1;
			order <= '{dir ? css_pkg::FC_SETUP_B : css_pkg::FC_SETUP_A, chan, count, host_addr};
		end
		else if (step_q == 2'h1)
		begin
			step_q <= 2'h2;
			order_valid <= 1'b1;
			order <= '{css_pkg::FC_RAMCTL, chan, {2'h0, ram_addr}, 16'h0000};
		end
		else if (step_q == 2'h2)
		begin
			step_q <= 2'h0;
			order_valid <= 1'b1;
			order <= '{css_pkg::FC_PCTL, chan, {ram_hi, ~ram_hi, 13'h0000, rr}, 16'h0000};
		end
		else
		begin
			order_valid <= 1'b0;
			order <= ~order; // Stale fields flip each idle cycle, back to the last order every other one
		end
	end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the channel service scheduler
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam int LIMIT = 20000;
	int               seed = 26;
	int               n_fail = 0, n_tests = 0, n_cyc = 0, i, k, t0, t1;
	int               n_save = 0, n_tally = 0, n_rtt = 0, n_ans = 0, n_xreq = 0, n_evt = 0, n_stop = 0, n_intr = 0;
	logic             clock = 1'b0, arst_n = 1'b0, start = 1'b0, rd_load = 1'b0, ram_hi = 1'b0, dir = 1'b0;
	logic             xfer_byte_done = 1'b0, xfer_error = 1'b0, blk_valid = 1'b0, blk_wr_done = 1'b0;
	logic [3:0]       x_chan = 4'h0, blk_line = 4'h0, rtt_c;
	logic [15:0]      count = 16'h0000, host_addr = 16'h0000, last_ans, a1;
	logic [13:0]      ram_addr = 14'h0000, blk_addr = 14'h0000, last_pc;
	logic [15:0]      data_req_hi = 16'h0000, data_req_lo = 16'h0000, pause_dis = 16'h0000;
	logic [15:0]      evt_ptr_nz = 16'h0004, scan_en = 16'h0000, blk_level_set = 16'h0020;
	logic [15:0][7:0] activity = '0;
	logic [7:0]       scan_status = 8'h00, scan_mask = 8'h00;
	logic [13:0]      corner [8] = '{14'h0000, 14'h01ff, 14'h0200, 14'h0dff, 14'h0e00, 14'h0fff, 14'h1000, 14'h3fff};
	logic             order_valid, rtt_e;
	logic             rd_d = 1'b0, act_d = 1'b0, act_e = 1'b0, rr_on = 1'b0;
	logic [7:0]       prev_s [16] = '{default: 8'h00};
	css_pkg::order_t  order;
	css_pkg::instr_t  instr = '0;
	css_pkg::svc_t    grant_q;
	css_pkg::region_t blk_region_q;
	logic [3:0]       grant_chan_q, rtt_chan_q, scan_chan_q, blk_chan_q;
	logic [13:0]      pc_q, xfer_ram_addr_q, blk_phys_q;
	logic [15:0]      xfer_host_addr_q, answer_q;
	logic             ctx_save_q, ctx_separate_q, tally_inc_q, pc_load_q, xfer_req_q, xfer_dir_q, xfer_ram_sel_q;
	logic             rtt_set_q, rtt_err_q, answer_valid_q, scan_rd_q, scan_act_q, blk_stop_q, blk_intr_q;

	host_cpu_model host (.clock(clock), .start(start), .rd_load(rd_load), .busy(xfer_req_q), .chan(x_chan),
		.dir(dir), .ram_hi(ram_hi), .rr(rr_on), .count(count), .host_addr(host_addr), .ram_addr(ram_addr),
		.order_valid(order_valid), .order(order));
	channel_service_scheduler dut (.*);

	always #5 clock = ~clock;
	// ====
	// Monitors
	// Pulse tallies and payloads, sampled on the rising edge
	always @(posedge clock)
	begin
		n_cyc++;
		if (ctx_save_q === 1'b1) n_save++;
		if (tally_inc_q === 1'b1) n_tally++;
		if (xfer_req_q === 1'b1) n_xreq++;
		if (grant_q === css_pkg::SVC_EVENT) n_evt++;
		if (blk_stop_q === 1'b1) n_stop++;
		if (blk_intr_q === 1'b1) n_intr++;
		if (answer_valid_q === 1'b1) n_ans++;
		if (answer_valid_q === 1'b1) last_ans = answer_q;
		if (pc_load_q === 1'b1) last_pc = pc_q;
		if (rtt_set_q === 1'b1) n_rtt++;
		if (rtt_set_q === 1'b1) {rtt_e, rtt_c} = {rtt_err_q, rtt_chan_q};
		// Scan model: status read one edge after the read pulse, verdict one edge later
		if (act_d) chk("scan_act", {15'h0000, act_e}, {15'h0000, scan_act_q});
		act_d = rd_d;
		if (rd_d) act_e = scan_en[scan_chan_q] && |((scan_status ^ prev_s[scan_chan_q]) & scan_mask);
		if (rd_d) prev_s[scan_chan_q] = scan_status;
		rd_d = scan_rd_q === 1'b1;
		if (n_cyc == LIMIT) n_fail++;
		if (n_cyc == LIMIT) finish_test();
	end
	// Scan data is random noise; changes land between edges
	always @(negedge clock) {scan_status, scan_mask} <= 16'($random(seed));
	// ====
	// Helpers
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test;
		if (n_fail == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	// Flags are {io, io_in, wait_y, call, ret}; valid for one cycle only
	task automatic op(input logic [4:0] f, input logic [2:0] lr);
		@(negedge clock);
		{instr.io, instr.io_in, instr.wait_y, instr.call, instr.ret} <= f;
		instr.lr <= lr;
		instr.valid <= 1'b1;
		@(negedge clock);
		instr.valid <= 1'b0;
	endtask
	// Bounded wait for a grant level, then the chosen channel
	task automatic grab(input logic [3:0] ch, input css_pkg::svc_t s);
		for (k = 0; k < 60 && grant_q !== s; k++) @(negedge clock);
		chk("grant_chan", {12'h000, ch}, {12'h000, grant_chan_q});
	endtask
	task automatic xstart(input logic [3:0] ch, input logic [15:0] n);
		x_chan <= ch;
		count <= n;
		dir <= n[0];
		ram_hi <= ~n[0];
		host_addr <= 16'($random(seed));
		ram_addr <= 14'($random(seed));
		start <= 1'b1;
		tick(1);
		start <= 1'b0;
	endtask
	// Moves bytes one pause at a time; an error cuts in on the second byte
	task automatic xrun(input logic [3:0] ch, input logic [15:0] n, input logic e);
		t0 = n_tally;
		t1 = n_rtt;
		for (i = 0; i < n; i++)
		begin
			for (k = 0; k < 60 && xfer_req_q !== 1'b1; k++) @(negedge clock);
			chk("xfer_host", host_addr + i[15:0], xfer_host_addr_q);
			chk("xfer_ram", {2'h0, ram_addr + i[13:0]}, {2'h0, xfer_ram_addr_q});
			chk("xfer_dir_sel", {14'h0000, dir, ram_hi}, {14'h0000, xfer_dir_q, xfer_ram_sel_q});
			xfer_error <= e && i == 1;
			xfer_byte_done <= !(e && i == 1);
			tick(1);
			xfer_byte_done <= 1'b0;
			xfer_error <= 1'b0;
			tick(1);
			if (e && i == 1) break;
		end
		tick(4);
		chk("rtt_count", t1[15:0] + 16'h0001, n_rtt[15:0]);
		chk("rtt_flags", {11'h000, e, ch}, {11'h000, rtt_e, rtt_c});
		chk("xfer_tally", t0[15:0], n_tally[15:0]);
	endtask
	function automatic logic [1:0] exp_rg(input logic [13:0] a);
		if (a <= css_pkg::LINE_TOP) return 2'h0;
		if (a >= css_pkg::CCB_LO && a <= css_pkg::CCB_HI) return 2'h1;
		return 2'h2;
	endfunction
	function automatic logic [3:0] first(input logic [15:0] r);
		first = 4'h0;
		for (int j = 15; j >= 0; j--) if (r[j]) first = j[3:0];
	endfunction
	// ====
	// Main sequence
	initial
	begin
		instr.vector = 14'h0123;
		instr.next_pc = 14'h0456;
		scan_en = 16'($random(seed));
		tick(12);
		arst_n <= 1'b1;
		tick(2);
		// Load monitor: one answer a read, and the count moves while idle
		for (i = 0; i < 2; i++)
		begin
			a1 = last_ans;
			rd_load <= 1'b1;
			tick(1);
			rd_load <= 1'b0;
			tick(40);
		end
		chk("load_answers", 16'h0002, n_ans[15:0]);
		chk("load_moved", 16'h0001, {15'h0000, last_ans != a1});
		// Block map: the corners first, then random addresses and lines
		for (i = 0; i < 24; i++)
		begin
			blk_valid <= 1'b1;
			blk_addr <= (i < 8) ? corner[i] : 14'($random(seed));
			blk_line <= 4'($random(seed));
			tick(1);
			chk("blk_region", {14'h0000, exp_rg(blk_addr)}, {14'h0000, blk_region_q});
			if (exp_rg(blk_addr) != 2'h2) chk("blk_phys", {2'h0, blk_line[3], blk_addr[12:0]}, {2'h0, blk_phys_q});
			blk_valid <= 1'b0;
			tick(1);
		end
		// Block write end on a line with a level and on one without
		for (i = 5; i < 10; i += 4)
		begin
			blk_line <= i[3:0];
			blk_wr_done <= 1'b1;
			tick(1);
			chk("blk_chan", i[15:0], {12'h000, blk_chan_q});
			blk_wr_done <= 1'b0;
			tick(2);
		end
		chk("blk_stop_intr", 16'h0201, {n_stop[7:0], n_intr[7:0]});
		// Transfer held off by data service, then done and error runs
		data_req_lo <= 16'h0008;
		grab(4'h3, css_pkg::SVC_DATA);
		t0 = n_xreq;
		xstart(4'h3, 16'h0003);
		tick(20);
		chk("xfer_held", t0[15:0], n_xreq[15:0]);
		data_req_lo <= 16'h0000;
		op(5'b00100, 3'h0);
		xrun(4'h3, 16'h0003, 1'b0);
		xstart(4'h7, 16'h0004);
		xrun(4'h7, 16'h0004, 1'b1);
		// Fixed data priority over a pending event
		activity[2] <= 8'h80;
		for (i = 0; i < 8; i++)
		begin
			data_req_hi <= (i < 2) ? 16'h0000 : 16'($random(seed) & $random(seed));
			data_req_lo <= 16'($random(seed)) | 16'h8000;
			tick(1);
			grab(first(data_req_hi != 16'h0000 ? data_req_hi : data_req_lo), css_pkg::SVC_DATA);
			data_req_hi <= 16'h0000;
			data_req_lo <= 16'h0000;
			op(5'b00100, 3'h0);
		end
		grab(4'h2, css_pkg::SVC_EVENT);
		chk("ctx_separate", 16'h0001, {15'h0000, ctx_separate_q});
		activity[2] <= 8'h00;
		t0 = n_save;
		op(5'b00100, 3'h0);
		tick(2);
		chk("event_yield", t0[15:0] + 16'h0001, n_save[15:0]);
		// Low activity bits alone never ask for event service
		activity[6] <= 8'h03;
		t0 = n_evt;
		tick(40);
		chk("event_low_bits", t0[15:0], n_evt[15:0]);
		activity[6] <= 8'h00;
		// Forced pause after 32 instructions, and on line register access
		data_req_lo <= 16'h0010;
		grab(4'h4, css_pkg::SVC_DATA);
		t0 = n_tally;
		repeat (31) op(5'b00000, 3'h0);
		chk("tally_early", t0[15:0], n_tally[15:0]);
		op(5'b00000, 3'h0);
		grab(4'h4, css_pkg::SVC_DATA);
		chk("tally_forced", t0[15:0] + 16'h0001, n_tally[15:0]);
		op(5'b11000, 3'h5);
		op(5'b10000, 3'h2);
		tick(1);
		chk("io_free", t0[15:0] + 16'h0001, n_tally[15:0]);
		op(5'b10000, 3'h3);
		grab(4'h4, css_pkg::SVC_DATA);
		chk("io_pause", t0[15:0] + 16'h0002, n_tally[15:0]);
		pause_dis <= 16'h0010;
		repeat (33) op(5'b00000, 3'h0);
		op(5'b10000, 3'h3);
		tick(1);
		chk("pause_off", t0[15:0] + 16'h0002, n_tally[15:0]);
		// Vectored call and return through the channel stack
		op(5'b00010, 3'h0);
		instr.next_pc <= 14'h0789;
		tick(2);
		chk("call_pc", 16'h0123, {2'h0, last_pc});
		op(5'b00001, 3'h0);
		tick(2);
		chk("ret_pc", 16'h0456, {2'h0, last_pc});
		data_req_lo <= 16'h0000;
		op(5'b00100, 3'h0);
		tick(5);
		// Round robin chosen by the control order: after line 4, line 5 beats line 0
		rr_on <= 1'b1;
		xstart(4'h1, 16'h0001);
		xrun(4'h1, 16'h0001, 1'b0);
		for (i = 0; i < 2; i++)
		begin
			data_req_lo <= 16'h0021;
			grab(i ? 4'h0 : 4'h5, css_pkg::SVC_DATA);
			data_req_lo <= 16'h0000;
			op(5'b00100, 3'h0);
		end
		tick(2);
		finish_test();
	end
endmodule
`default_nettype wire
